// *** dv/input_decoder_checker.sv ***
// Purpose: port checks for input_decoder
// Assumes: clk_en held high
// Notes: shadows only the code words and the closed-loop ctrl bit it relies on
`timescale 1ns/1ps
`include "input_decoder_defs.vh"
module input_decoder_checker (
   // Bus
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   // Terminals and status
   input wire [7:0] term_in,
   input wire at_reference,
   input wire trip_locked,
   // Commands
   input wire run_cmd,
   input wire reverse_cmd,
   input wire coast_cmd,
   input wire ext_fault_alarm,
   input wire alarm_active,
   input wire feedback_high_warn
);
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [31:0] codes_a;
   logic [7:0] stop_code;
   logic closed;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Write shadow, so checks follow the active codes
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         codes_a <= `CODES_A_RESET;
         stop_code <= 8'h00;
         closed <= 1'b0;
      end
      else
      begin
         wr_pend <= hsel & htrans[1] & hwrite & hready;
         wr_addr <= haddr[7:0];
         if (wr_pend && wr_addr == `REG_CODES_A)
            codes_a <= hwdata;
         if (wr_pend && wr_addr == `REG_CODES_B)
            stop_code <= hwdata[7:0];
         if (wr_pend && wr_addr == `REG_CTRL)
            closed <= hwdata[0];
      end
   end
   a_coast_stop: assert property (
      (stop_code == 8'h00 && $stable(term_in[4]))[*4]
      |-> coast_cmd == !term_in[4]) else $error("coast wrong");
   a_reset_coast: assert property (
      (stop_code == 8'h01 && !term_in[4])[*4] |-> coast_cmd)
      else $error("reset coast missing");
   a_interlock_low: assert property (
      (stop_code == 8'h03 && !term_in[4])[*4]
      |-> coast_cmd && ext_fault_alarm) else $error("interlock wrong");
   a_start_runs: assert property (
      (codes_a[23:16] == 8'h01 && term_in[2] && term_in[4]
      && stop_code == 8'h00)[*4] |-> run_cmd) else $error("no run");
   a_dir_follows: assert property (
      (codes_a[31:24] == 8'h01 && !closed && $stable(term_in[3]))[*4]
      |-> reverse_cmd == term_in[3]) else $error("direction wrong");
   a_warn_at_ref: assert property (
      !at_reference[*3] |-> !feedback_high_warn)
      else $error("warning before reference");
   a_warn_running: assert property (
      !run_cmd[*3] |-> !feedback_high_warn)
      else $error("warning while stopped");
   a_trip_holds: assert property (
      (alarm_active && trip_locked)[*2] |=> alarm_active)
      else $error("trip locked alarm cleared");
   cover property (coast_cmd && ext_fault_alarm);
   cover property (run_cmd && reverse_cmd);
   cover property ($fell(alarm_active));
endmodule // input_decoder_checker

bind input_decoder input_decoder_checker input_decoder_checker_i (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .term_in, .at_reference, .trip_locked, .run_cmd, .reverse_cmd,
   .coast_cmd, .ext_fault_alarm, .alarm_active, .feedback_high_warn);

// *** dv/input_decoder_tb.sv ***
// Purpose: self-checking bench for input_decoder
// Assumes: zero-wait AHB-Lite slave, short nudge counts
// Notes: terminals settle within five cycles
`timescale 1ns/1ps
`include "input_decoder_defs.vh"
module input_decoder_tb;
   localparam int NC = 4;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic clk_en = 1'b1, at_reference = 1'b0, trip_locked = 1'b0;
   logic fault_event = 1'b0, off_key = 1'b0, rev_run = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic [7:0] want = 8'h00;
   logic [7:0] cfg [8];
   int n_mismatch = 0, tests_run = 0;
   wire hreadyout, hresp, run_cmd, reverse_cmd, coast_cmd, dc_brake_cmd;
   wire ext_fault_alarm, alarm_active, preset_on, inch_cmd, prog_lock;
   wire pulse_ref_en, pulse_fb_en, hand_mode, remote_mode_select;
   wire feedback_high_warn;
   wire [1:0] setup_sel, preset_sel, digital_out, relay_out;
   wire [31:0] hrdata;
   wire [7:0] term_in;
   input_decoder #(.NUDGE_CYCLES(NC), .RAMP_CYCLES(16), .FLASH_W(3))
      input_decoder_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .term_in(term_in), .at_reference(at_reference),
      .trip_locked(trip_locked), .fault_event(fault_event),
      .off_key(off_key), .run_cmd(run_cmd), .reverse_cmd(reverse_cmd),
      .coast_cmd(coast_cmd), .dc_brake_cmd(dc_brake_cmd),
      .ext_fault_alarm(ext_fault_alarm), .alarm_active(alarm_active),
      .setup_sel(setup_sel), .preset_on(preset_on),
      .preset_sel(preset_sel), .inch_cmd(inch_cmd),
      .prog_lock(prog_lock), .pulse_ref_en(pulse_ref_en),
      .pulse_fb_en(pulse_fb_en), .hand_mode(hand_mode),
      .remote_mode_select(remote_mode_select),
      .feedback_high_warn(feedback_high_warn),
      .digital_out(digital_out), .relay_out(relay_out));
   switch_bank switch_bank_i (.hclk, .want, .rev_run, .term_in);
   initial forever #20 hclk = ~hclk;
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask
   task automatic code(input int t, input logic [7:0] c);
      cfg[t] = c;
      if (t < 4)
         wr(`REG_CODES_A, {cfg[3], cfg[2], cfg[1], cfg[0]});
      else
         wr(`REG_CODES_B, {cfg[7], cfg[6], cfg[5], cfg[4]});
   endtask
   task automatic fault;
      fault_event <= 1'b1;
      cyc(1);
      fault_event <= 1'b0;
      cyc(5);
   endtask
   task automatic t_regs;
      logic [31:0] q;
      rd(`REG_FB_LIMIT, q);
      chk("limit reset", q, 32'd999999999);
      wr(`REG_FB_LIMIT, 32'hffffffff);
      rd(`REG_FB_LIMIT, q);
      chk("limit cap", q, 32'd999999999);
      wr(`REG_FEEDBACK, 32'hffffffff);
      chk("warn stopped", feedback_high_warn, 1'b0);
      rd(8'h40, q);
      chk("unmapped", q, 32'h0);
      chk("okay", hresp, 1'b0);
   endtask
   task automatic t_stop;
      wr(`REG_BRAKE, 32'hffff0001);
      for (int c = 0; c < 4; c++)
      begin
         code(4, c[7:0]);
         want[4] <= 1'b0;
         cyc(5);
         chk("coast", coast_cmd, c != 2);
         chk("brake", dc_brake_cmd, c == 2);
         chk("ext fault", ext_fault_alarm, c == 3);
         want[4] <= 1'b1;
         off_key <= 1'b1;
         cyc(5);
         off_key <= 1'b0;
         chk("coast off", coast_cmd, 1'b0);
      end
      // Zero current must leave braking off
      wr(`REG_BRAKE, 32'hffff0000);
      code(4, 8'h02);
      want[4] <= 1'b0;
      cyc(5);
      chk("brake off", dc_brake_cmd, 1'b0);
      want[4] <= 1'b1;
      code(4, 8'h00);
   endtask
   task automatic t_alarm;
      code(0, 8'h01);
      fault;
      chk("alarm set", alarm_active, 1'b1);
      want[0] <= 1'b1;
      cyc(5);
      chk("reset rise", alarm_active, 1'b0);
      trip_locked <= 1'b1;
      fault;
      want[0] <= 1'b0;
      cyc(5);
      want[0] <= 1'b1;
      cyc(5);
      chk("trip locked", alarm_active, 1'b1);
      trip_locked <= 1'b0;
      code(0, 8'h00);
      want[0] <= 1'b0;
      cyc(5);
      want[0] <= 1'b1;
      cyc(5);
      chk("no function", alarm_active, 1'b1);
      code(4, 8'h01);
      want[4] <= 1'b0;
      cyc(5);
      chk("fall reset", alarm_active, 1'b0);
      want[4] <= 1'b1;
      code(4, 8'h00);
   endtask
   task automatic t_start;
      code(2, 8'h01);
      code(3, 8'h01);
      want[3:2] <= 2'b11;
      cyc(5);
      chk("run", {run_cmd, reverse_cmd}, 2'b11);
      want[2] <= 1'b0;
      cyc(5);
      chk("stop", {run_cmd, reverse_cmd}, 2'b01);
      code(2, 8'h00);
      want[2] <= 1'b1;
      cyc(5);
      chk("start off", run_cmd, 1'b0);
      wr(`REG_CTRL, 32'h1);
      cyc(5);
      chk("closed loop", reverse_cmd, 1'b0);
      wr(`REG_CTRL, 32'h0);
      rev_run <= 1'b1;
      code(2, 8'h01);
      code(3, 8'h02);
      cyc(5);
      chk("rev run", {run_cmd, reverse_cmd}, 2'b11);
      want[3:2] <= 2'b00;
      rev_run <= 1'b0;
      cyc(5);
      chk("rev run off", run_cmd, 1'b0);
   endtask
   task automatic t_warn;
      int nw = 0, nd = 0, nr = 0;
      wr(`REG_ROUTE, 32'h91);
      want[2] <= 1'b1;
      at_reference <= 1'b1;
      cyc(6);
      // half of every blink period shows
      repeat (8)
      begin
         @(posedge hclk);
         nw += (feedback_high_warn === 1'b1);
         nd += (digital_out === 2'b01);
         nr += (relay_out === 2'b01);
      end
      chk("warn flash", nw, 4);
      chk("warn digital", nd, 4);
      chk("warn relay", nr, 4);
      at_reference <= 1'b0;
      cyc(4);
      chk("warn off", {feedback_high_warn, digital_out}, 3'h0);
      code(4, 8'h03);
      want[4] <= 1'b0;
      cyc(6);
      chk("fault relay", relay_out, 2'b10);
      want[4] <= 1'b1;
      off_key <= 1'b1;
      cyc(5);
      off_key <= 1'b0;
      want[2] <= 1'b0;
      code(4, 8'h00);
   endtask
   task automatic t_codes;
      int tt[14] = '{5, 5, 5, 5, 5, 5, 1, 7, 6, 0, 7, 1, 6, 7};
      int cc[14] = '{6, 12, 13, 14, 15, 16, 11, 11, 12, 11, 12, 13, 9, 10};
      int bb[14] = '{0, 3, 2, 1, 5, 4, 1, 6, 4, 5, 5, 4, 3, 2};
      for (int i = 0; i < 14; i++)
      begin
         code(tt[i], cc[i][7:0]);
         want[tt[i]] <= 1'b1;
         cyc(5);
         chk("code", {pulse_fb_en, hand_mode, remote_mode_select, inch_cmd,
             prog_lock, pulse_ref_en, preset_on}, 32'h1 << bb[i]);
         want[tt[i]] <= 1'b0;
         code(tt[i], 8'h00);
      end
      code(6, 8'h04);
      code(7, 8'h04);
      want[7:6] <= 2'b10;
      cyc(5);
      chk("single set", setup_sel, 2'b00);
      wr(`REG_CTRL, 32'h2);
      cyc(5);
      chk("setup", setup_sel, 2'b10);
      code(0, 8'h06);
      code(1, 8'h06);
      want[1:0] <= 2'b10;
      cyc(5);
      chk("preset", preset_sel, 2'b10);
      want[1:0] <= 2'b00;
      code(0, 8'h00);
      code(1, 8'h00);
      want[7:6] <= 2'b00;
      wr(`REG_CTRL, 32'h0);
   endtask
   task automatic t_nudge;
      logic [31:0] q;
      wr(`REG_REFERENCE, 32'h64);
      code(0, 8'h02);
      code(6, 8'h07);
      code(7, 8'h07);
      want[0] <= 1'b1;
      cyc(5);
      rd(`REG_HELD, q);
      chk("held", q, 32'h64);
      for (int k = 6; k < 8; k++)
      begin
         // pulse and pause both longer than the minimum
         want[k] <= 1'b1;
         cyc(NC + 2);
         want[k] <= 1'b0;
         cyc(NC + 2);
         rd(`REG_HELD, q);
         chk("nudge", q, k == 6 ? 32'h65 : 32'h64);
      end
      wr(`REG_REFERENCE, 32'h200);
      cyc(5);
      rd(`REG_HELD, q);
      chk("held kept", q, 32'h64);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #(20000 * 40);
      n_mismatch++;
      tally_and_finish;
   end
   initial
   begin
      {cfg[3], cfg[2], cfg[1], cfg[0]} = `CODES_A_RESET;
      {cfg[7], cfg[6], cfg[5], cfg[4]} = `CODES_B_RESET;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs;
      t_stop;
      t_alarm;
      t_start;
      t_warn;
      t_codes;
      t_nudge;
      tally_and_finish;
   end
endmodule // input_decoder_tb

// *** dv/switch_bank.sv ***
// Purpose: external contacts driving the terminals
// Assumes: contacts change just after a clock edge
// Notes: solid 24 V levels, never left floating
`timescale 1ns/1ps
module switch_bank (
   // Clock
   input logic hclk,
   // Requested contact states
   input logic [7:0] want,
   input logic rev_run,
   // Terminal levels
   output logic [7:0] term_in
);
   initial term_in = 8'h00;
   always @(posedge hclk)
   begin
      term_in <= want & ~{5'h00, rev_run, 2'b00};
   end
endmodule // switch_bank

// *** shared/input_decoder_defs.vh ***
// Purpose: constants for the digital input decoder
// Assumes: hclk at 25 MHz, AHB-Lite register access
`ifndef INPUT_DECODER_DEFS_VH
`define INPUT_DECODER_DEFS_VH
`define CLK_HZ 25000000
`define NUDGE_MIN_MS 3
`define NUDGE_CYCLES ((`NUDGE_MIN_MS * `CLK_HZ) / 1000)
`define NUDGE_RAMP_CYCLES 250000
// Warning blinks with the top bit of a counter this wide
`define FLASH_BITS 24
`define REG_CTRL 8'h00
`define REG_CODES_A 8'h04
`define REG_CODES_B 8'h08
`define REG_BRAKE 8'h0c
`define REG_FB_LIMIT 8'h10
`define REG_FEEDBACK 8'h14
`define REG_REFERENCE 8'h18
`define REG_OUTFREQ 8'h1c
`define REG_ROUTE 8'h20
`define REG_STATUS 8'h24
`define REG_HELD 8'h28
`define REG_ALARM 8'h2c
`define FB_LIMIT_RESET 32'h3b9ac9ff
`define CODES_A_RESET 32'h00010120
`define CODES_B_RESET 32'h00000c00
// Code values shared by terminal kinds
`define C_NONE 5'h00
`define C_RESET 5'h01
`define C_FREF 5'h02
`define C_FOUT 5'h03
`define F_NONE 5'h00
`define F_RESET 5'h01
`define F_FREF 5'h02
`define F_FOUT 5'h03
`define F_SET_LO 5'h04
`define F_SET_HI 5'h05
`define F_PRE_ON 5'h06
`define F_PRE_LO 5'h07
`define F_PRE_HI 5'h08
`define F_DOWN 5'h09
`define F_UP 5'h0a
`define F_PERMIT 5'h0b
`define F_INCH 5'h0c
`define F_LOCK 5'h0d
`define F_PULSE_REF 5'h0e
`define F_HAND 5'h0f
`define F_AUTO 5'h10
`define F_PULSE_FB 5'h11
`endif

// *** src/input_decoder.v ***
// Purpose: decode programmable digital inputs into drive commands
// Assumes: inputs synchronous to hclk, single AHB-Lite master
// Notes: zero-wait slave, every access OKAY
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "input_decoder_defs.vh"
module input_decoder #(
   parameter NUDGE_CYCLES = `NUDGE_CYCLES,
   parameter RAMP_CYCLES = `NUDGE_RAMP_CYCLES,
   parameter FLASH_W = `FLASH_BITS,
   parameter VAL_W = 32
)(
   // Clock, reset, enable
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Terminals: 0,1 low/high-bit general, 2 start, 3 direction,
   // 4 stop, 5 extended, 6,7 low/high-bit general
   input wire [7:0] term_in,
   // Drive status from the motor control
   input wire at_reference,
   input wire trip_locked,
   input wire fault_event,
   input wire off_key,
   // Drive commands
   output reg run_cmd,
   output reg reverse_cmd,
   output reg coast_cmd,
   output reg dc_brake_cmd,
   output reg ext_fault_alarm,
   output reg alarm_active,
   output reg [1:0] setup_sel,
   output reg preset_on,
   output reg [1:0] preset_sel,
   output reg inch_cmd,
   output reg prog_lock,
   output reg pulse_ref_en,
   output reg pulse_fb_en,
   output reg hand_mode,
   output reg remote_mode_select,
   output reg feedback_high_warn,
   output reg [1:0] digital_out,
   output reg [1:0] relay_out
);
   // Registers
   reg [31:0] ctrl;
   reg [31:0] codes_a;
   reg [31:0] codes_b;
   reg [31:0] brake_cfg;
   reg [31:0] feedback_upper_limit;
   reg [31:0] feedback;
   reg [31:0] reference;
   reg [31:0] out_freq;
   reg [31:0] route;
   reg [VAL_W-1:0] held_value;
   reg [7:0] term_q;
   reg [7:0] term_prev;
   reg ap_write;
   reg ap_read;
   reg [7:0] ap_addr;
   reg [FLASH_W-1:0] flash_cnt;
   // One step flag per nudge direction
   wire [1:0] nudge_step;
   wire closed_loop = ctrl[0];
   wire multi_set = ctrl[1];
   wire hold_ref = ctrl[2];
   wire hold_out = ctrl[3];

   // Maps each terminal code onto a common function number
   function [4:0] map_code;
      input [2:0] term;
      input [4:0] code;
      begin
         map_code = `F_NONE;
         if (term == 3'd5)
            map_code = (code > 5'd16) ? `F_NONE : code;
         else if (code < 5'd4)
            map_code = code;
         else if (term == 3'd0 || term == 3'd6)
         begin
            case (code)
               5'd4: map_code = `F_SET_LO;
               5'd5: map_code = `F_PRE_ON;
               5'd6: map_code = `F_PRE_LO;
               5'd7: map_code = `F_UP;
               5'd8: map_code = `F_PERMIT;
               5'd9: map_code = `F_INCH;
               5'd10: map_code = `F_LOCK;
               5'd11: map_code = `F_HAND;
               5'd12: map_code = `F_AUTO;
               default: map_code = `F_NONE;
            endcase
         end
         else
         begin
            case (code)
               5'd4: map_code = `F_SET_HI;
               5'd5: map_code = `F_PRE_ON;
               5'd6: map_code = `F_PRE_HI;
               5'd7: map_code = `F_DOWN;
               5'd8: map_code = `F_PERMIT;
               5'd9: map_code = `F_INCH;
               5'd10: map_code = `F_LOCK;
               5'd11: map_code = (term == 3'd1) ? `F_PULSE_REF : `F_PULSE_FB;
               5'd12: map_code = `F_HAND;
               5'd13: map_code = `F_AUTO;
               default: map_code = `F_NONE;
            endcase
         end
      end
   endfunction

   // Bus slave, zero wait states
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_write <= 1'b0;
         ap_read <= 1'b0;
         ap_addr <= 8'h00;
      end
      else if (clk_en && hready)
      begin
         ap_write <= hsel && htrans[1] && hwrite;
         ap_read <= hsel && htrans[1] && !hwrite;
         ap_addr <= haddr[7:0];
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         term_q <= 8'h00;
         term_prev <= 8'h00;
      end
      else if (clk_en)
      begin
         term_q <= term_in;
         term_prev <= term_q;
      end
   end
   wire [7:0] rise = term_q & ~term_prev;
   wire [7:0] fall = ~term_q & term_prev;

   // Per-terminal function decode
   reg [4:0] fn [0:7];
   reg [17:0] lvl;
   reg [17:0] rise_f;
   reg [4:0] tcode;
   integer i;
   always @*
   begin
      lvl = 18'h00000;
      rise_f = 18'h00000;
      for (i = 0; i < 8; i = i + 1)
      begin
         tcode = (i < 4) ? codes_a[i*8 +: 5] : codes_b[(i-4)*8 +: 5];
         if (i == 2 || i == 3 || i == 4)
            fn[i] = `F_NONE;
         else
            fn[i] = map_code(i[2:0], tcode);
         if (fn[i] != `F_NONE)
         begin
            lvl[fn[i]] = lvl[fn[i]] | term_q[i];
            rise_f[fn[i]] = rise_f[fn[i]] | rise[i];
         end
      end
   end

   // Fixed-kind terminals
   wire [4:0] start_code = codes_a[20:16];
   wire [4:0] dir_code = codes_a[28:24];
   wire [4:0] stop_code = codes_b[4:0];
   wire brake_ok = (brake_cfg[15:0] != 16'h0000) &&
      (brake_cfg[31:16] != 16'h0000);
   wire permit_ok = !(|{fn[0] == `F_PERMIT, fn[1] == `F_PERMIT,
      fn[5] == `F_PERMIT, fn[6] == `F_PERMIT, fn[7] == `F_PERMIT}) ||
      lvl[`F_PERMIT];
   wire reset_pulse = rise_f[`F_RESET] ||
      (stop_code == 5'd1 && fall[4]) || off_key;
   wire nudge_en = lvl[`F_FREF] || lvl[`F_FOUT] || hold_ref || hold_out;
   wire warn_raw = feedback > feedback_upper_limit;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         run_cmd <= 1'b0;
         reverse_cmd <= 1'b0;
         coast_cmd <= 1'b0;
         dc_brake_cmd <= 1'b0;
         ext_fault_alarm <= 1'b0;
         alarm_active <= 1'b0;
         setup_sel <= 2'h0;
         preset_on <= 1'b0;
         preset_sel <= 2'h0;
         inch_cmd <= 1'b0;
         prog_lock <= 1'b0;
         pulse_ref_en <= 1'b0;
         pulse_fb_en <= 1'b0;
         hand_mode <= 1'b0;
         remote_mode_select <= 1'b0;
         feedback_high_warn <= 1'b0;
         digital_out <= 2'h0;
         relay_out <= 2'h0;
         flash_cnt <= {FLASH_W{1'b0}};
      end
      else if (clk_en)
      begin
         run_cmd <= permit_ok && ((start_code == 5'd1 && term_q[2]) ||
            (dir_code == 5'd2 && !closed_loop && term_q[3]) ||
            lvl[`F_INCH]);
         reverse_cmd <= !closed_loop && (dir_code == 5'd1 ||
            dir_code == 5'd2) && term_q[3];
         coast_cmd <= stop_code != 5'd2 && !term_q[4];
         dc_brake_cmd <= brake_ok &&
            ((stop_code == 5'd2 && !term_q[4]) ||
            (dir_code == 5'd3 && !term_q[3]));
         if (stop_code == 5'd3 && !term_q[4])
            ext_fault_alarm <= 1'b1;
         else if (reset_pulse)
            ext_fault_alarm <= 1'b0;
         if (fault_event || (stop_code == 5'd3 && !term_q[4]))
            alarm_active <= 1'b1;
         else if (reset_pulse && !trip_locked)
            alarm_active <= 1'b0;
         setup_sel <= multi_set ? {lvl[`F_SET_HI], lvl[`F_SET_LO]} : 2'h0;
         preset_on <= lvl[`F_PRE_ON];
         preset_sel <= {lvl[`F_PRE_HI], lvl[`F_PRE_LO]};
         inch_cmd <= lvl[`F_INCH];
         prog_lock <= lvl[`F_LOCK];
         pulse_ref_en <= fn[1] == `F_PULSE_REF || fn[5] == `F_PULSE_REF;
         pulse_fb_en <= fn[7] == `F_PULSE_FB;
         hand_mode <= lvl[`F_HAND] && !lvl[`F_AUTO];
         remote_mode_select <= lvl[`F_AUTO];
         flash_cnt <= flash_cnt + {{(FLASH_W-1){1'b0}}, 1'b1};
         feedback_high_warn <= warn_raw && at_reference && run_cmd &&
            flash_cnt[FLASH_W-1];
         digital_out <= route[1:0] & {2{feedback_high_warn}} |
            route[3:2] & {2{ext_fault_alarm}};
         relay_out <= route[5:4] & {2{feedback_high_warn}} |
            route[7:6] & {2{ext_fault_alarm}};
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : nudge
         wire lv = (g == 0) ? lvl[`F_UP] : lvl[`F_DOWN];
         reg [23:0] hi_cnt;
         reg [23:0] lo_cnt;
         reg armed;
         reg step;
         assign nudge_step[g] = step;
         always @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               hi_cnt <= 24'h000000;
               lo_cnt <= 24'h000000;
               armed <= 1'b0;
               step <= 1'b0;
            end
            else if (clk_en)
            begin
               step <= 1'b0;
               if (lv)
               begin
                  lo_cnt <= 24'h000000;
                  if (hi_cnt == NUDGE_CYCLES[23:0] - 24'h000001 && armed)
                     step <= 1'b1;
                  if (hi_cnt == RAMP_CYCLES[23:0] - 24'h000001)
                  begin
                     hi_cnt <= NUDGE_CYCLES[23:0];
                     step <= 1'b1;
                  end
                  else
                     hi_cnt <= hi_cnt + 24'h000001;
               end
               else
               begin
                  hi_cnt <= 24'h000000;
                  if (lo_cnt >= NUDGE_CYCLES[23:0] - 24'h000001)
                     armed <= 1'b1;
                  else
                     lo_cnt <= lo_cnt + 24'h000001;
               end
               if (lv && hi_cnt == NUDGE_CYCLES[23:0] - 24'h000001)
                  armed <= 1'b0;
            end
         end
      end
   endgenerate

   // Register writes and held value
   wire hold_start = (rise_f[`F_FREF] || rise_f[`F_FOUT]);
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl <= 32'h00000000;
         codes_a <= `CODES_A_RESET;
         codes_b <= `CODES_B_RESET;
         brake_cfg <= 32'h00000000;
         feedback_upper_limit <= `FB_LIMIT_RESET;
         feedback <= 32'h00000000;
         reference <= 32'h00000000;
         out_freq <= 32'h00000000;
         route <= 32'h00000000;
         held_value <= {VAL_W{1'b0}};
      end
      else if (clk_en)
      begin
         if (ap_write)
         begin
            case (ap_addr)
               `REG_CTRL: ctrl <= hwdata;
               `REG_CODES_A: codes_a <= hwdata;
               `REG_CODES_B: codes_b <= hwdata;
               `REG_BRAKE: brake_cfg <= hwdata;
               `REG_FB_LIMIT: feedback_upper_limit <=
                  (hwdata > `FB_LIMIT_RESET) ? `FB_LIMIT_RESET : hwdata;
               `REG_FEEDBACK: feedback <= hwdata;
               `REG_REFERENCE: reference <= hwdata;
               `REG_OUTFREQ: out_freq <= hwdata;
               `REG_ROUTE: route <= hwdata;
               default: ;
            endcase
         end
         if (hold_start)
            held_value <= rise_f[`F_FOUT] ? out_freq : reference;
         else if (nudge_en && nudge_step[0] && !nudge_step[1])
            held_value <= held_value + 1'b1;
         else if (nudge_en && nudge_step[1] && !nudge_step[0] &&
                  held_value != {VAL_W{1'b0}})
            held_value <= held_value - 1'b1;
      end
   end

   // Read data
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (clk_en && hready)
      begin
         case (haddr[7:0])
            `REG_CTRL: hrdata <= ctrl;
            `REG_CODES_A: hrdata <= codes_a;
            `REG_CODES_B: hrdata <= codes_b;
            `REG_BRAKE: hrdata <= brake_cfg;
            `REG_FB_LIMIT: hrdata <= feedback_upper_limit;
            `REG_FEEDBACK: hrdata <= feedback;
            `REG_REFERENCE: hrdata <= reference;
            `REG_OUTFREQ: hrdata <= out_freq;
            `REG_ROUTE: hrdata <= route;
            `REG_STATUS: hrdata <= {24'h000000, term_q};
            `REG_HELD: hrdata <= held_value;
            `REG_ALARM: hrdata <= {28'h0000000, dc_brake_cmd,
               feedback_high_warn, ext_fault_alarm, alarm_active};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end
endmodule // input_decoder
